// File: src/lpwc_map.vh
// lpwc_map.vh: offsets, field positions, reset values and source
// numbering for the low power wake control block.
// assumes: included once by the block's design file.
`ifndef LPWC_MAP_VH
`define LPWC_MAP_VH

// register byte offsets, one 32-bit word each
`define LPWC_OFS_MODE      8'h00
`define LPWC_OFS_WEN_LO    8'h04
`define LPWC_OFS_WEN_HI    8'h08
`define LPWC_OFS_IRQ_EN    8'h0c
`define LPWC_OFS_HW_SEL    8'h10
`define LPWC_OFS_CFG       8'h14
`define LPWC_OFS_STATUS    8'h18
`define LPWC_OFS_CAUSE     8'h1c

// mode request codes written to the mode register
`define LPWC_REQ_SLEEP     3'h1
`define LPWC_REQ_DSLEEP    3'h2
`define LPWC_REQ_DPD       3'h3
`define LPWC_REQ_FDPD      3'h4

// configuration bits
`define LPWC_CFG_RTC_KEEP  0
`define LPWC_CFG_CMP_KEEP  1
`define LPWC_CFG_RESET     2'h1

// wake source numbering, 24 sources
`define LPWC_NSRC          24
`define LPWC_NLO           16
`define LPWC_SRC_PIN       0
`define LPWC_SRC_RTC_1HZ   1
`define LPWC_SRC_RTC_ALARM 2
`define LPWC_SRC_RTC_WAKE  3
`define LPWC_SRC_UTICK     4
`define LPWC_SRC_OSTIMER   5
`define LPWC_SRC_DMA       6
`define LPWC_SRC_DIGITAL_MICROPHONE_BLOCK      7
`define LPWC_SRC_OSPI      8
`define LPWC_SRC_SDIO      9
`define LPWC_SRC_CRYPTO    10
`define LPWC_SRC_MATHACC   11
`define LPWC_SRC_ADC       12
`define LPWC_SRC_PRIMARY_WATCHDOG      13
`define LPWC_SRC_WDT_OTHER 14
`define LPWC_SRC_USART     15
`define LPWC_SRC_SPI       16
`define LPWC_SRC_I2C       17
`define LPWC_SRC_I2S       18
`define LPWC_SRC_I3C       19
`define LPWC_SRC_USB       20
`define LPWC_SRC_CORE2     21
`define LPWC_SRC_CMP       22
`define LPWC_SRC_SPARE     23

// sources able to wake from deep-sleep: all but the secondary
// watchdog, the comparator and the spare slot
`define LPWC_DS_CAPABLE    24'h3fbfff
// sources kept alive through deep power-down: rtc alarm and wake
`define LPWC_DPD_CAPABLE   24'h00000c

// hardware activity wake lanes (serial blocks plus microphone)
`define LPWC_NHW           9
`define LPWC_HW_SEL_RESET  9'h000

`endif

// File: src/lpwc_core.v
// lpwc_core.v: power mode and wake control with a wishbone slave.
// assumes: one 100 MHz clock, synchronous active-high reset, wake
// inputs from other domains or pins, a classic wishbone master.
`include "lpwc_map.vh"
`default_nettype none

module lpwc_core (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // wake sources from peripherals and pins
    input  wire [23:0] irq_i,
    input  wire [8:0]  hw_act_i,
    input  wire        serial_slave_i,
    input  wire        usart_32k_i,
    input  wire        reset_pin_n_i,
    input  wire        supply_ok_i,
    input  wire        primary_watchdog_rst_i,
    input  wire        wdt_other_rst_i,
    // clock and power controls
    output reg         cpu_clk_en_o,
    output reg         main_clk_en_o,
    output reg         periph_clk_en_o,
    output reg         fro_en_o,
    output reg         osc_pwr_en_o,
    output reg         pll_pwr_en_o,
    output reg         sram_pwr_en_o,
    output reg         periph_pwr_en_o,
    output reg         rtc_pwr_en_o,
    output reg         cmp_pwr_en_o,
    output reg         wake_req_o,
    output reg         chip_reset_o
);

    // one-hot power mode states
    localparam [4:0] ST_ACTIVE = 5'h01;
    localparam [4:0] ST_SLEEP  = 5'h02;
    localparam [4:0] ST_DSLEEP = 5'h04;
    localparam [4:0] ST_DPD    = 5'h08;
    localparam [4:0] ST_FDPD   = 5'h10;

    // width of the synchronised input bundle
    localparam NIN = 24 + 9 + 6;

    reg  [4:0]  state_reg;          // current power mode
    reg  [4:0]  state_next;
    reg  [15:0] wen_lo_reg;         // wake_enable_lower
    reg  [7:0]  wen_hi_reg;         // wake_enable_upper
    reg  [23:0] irq_en_reg;         // core_interrupt_controller enables
    reg  [8:0]  hw_sel_reg;         // deep-sleep activity lane select
    reg  [1:0]  cfg_reg;            // rtc and comparator keep bits
    reg  [23:0] cause_reg;          // sticky record of wake causes
    reg  [NIN-1:0] sync1_reg;       // first stage, read by stage two only
    reg  [NIN-1:0] sync2_reg;       // second stage, safe to use
    reg  [2:0]  req_reg;            // pending mode entry request
    reg  [31:0] rd_data;
    wire [NIN-1:0] raw_in;

    // decoded synchronised inputs
    wire [23:0] irq_s;
    wire [8:0]  hw_s;
    wire        slave_s;
    wire        u32k_s;
    wire        rpin_s;
    wire        supply_s;
    wire        primary_watchdog_s;

    // qualified source vector and per-mode wake terms
    reg  [23:0] qual;
    wire [23:0] wen;
    wire [23:0] armed;
    wire        sleep_wake;
    wire        ds_wake;
    wire        dpd_wake;
    wire        wake_any;
    wire        bus_req;
    wire        bus_wr;

    // ---------------- input synchronisers ----------------
    assign raw_in = {wdt_other_rst_i, primary_watchdog_rst_i, supply_ok_i,
                     ~reset_pin_n_i, usart_32k_i, serial_slave_i,
                     hw_act_i, irq_i};

    // two flops per input: pins and slow-domain peripherals
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= {NIN{1'b0}};
            sync2_reg <= {NIN{1'b0}};
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    assign irq_s    = sync2_reg[23:0];
    assign hw_s     = sync2_reg[32:24];
    assign slave_s  = sync2_reg[33];
    assign u32k_s   = sync2_reg[34];
    assign rpin_s   = sync2_reg[35];
    assign supply_s = sync2_reg[36];
    assign primary_watchdog_s   = sync2_reg[37];
    // the secondary watchdog reset, bit 38, is deliberately unused

    // ---------------- source qualification ----------------
    // in deep-sleep, serial interrupts only count when the block runs
    // without an internal bus clock, since none exists there; sleep ignores this
    always @* begin
        qual = irq_s;
        qual[`LPWC_SRC_USART] = irq_s[`LPWC_SRC_USART]
                               & (slave_s | u32k_s);
        qual[`LPWC_SRC_SPI] = irq_s[`LPWC_SRC_SPI] & slave_s;
        qual[`LPWC_SRC_I2C] = irq_s[`LPWC_SRC_I2C] & slave_s;
        qual[`LPWC_SRC_I2S] = irq_s[`LPWC_SRC_I2S] & slave_s;
        qual[`LPWC_SRC_I3C] = irq_s[`LPWC_SRC_I3C] & slave_s;
    end

    assign wen   = {wen_hi_reg, wen_lo_reg};
    // interrupt controller enable gates every peripheral source in sleep and deep-sleep, not power-down
    assign armed = irq_s & irq_en_reg;

    // sleep: any enabled interrupt, any activity lane or the reset pin
    assign sleep_wake = (|armed)
                      | (|hw_s)
                      | rpin_s;

    // deep-sleep: capable mask drops comparator and other watchdog;
    // it keeps pins, rtc, timers, dma, digital_microphone_block, flash, sdio,
    // accelerators, adc, usb and the second core
    assign ds_wake = (|(qual & irq_en_reg & wen
                        & `LPWC_DS_CAPABLE))
                   | (|(hw_s & hw_sel_reg))
                   | rpin_s;
    // are bits of the capable mask above

    // power-down: rtc alarm and wake, plus the reset pin
    assign dpd_wake = (|(irq_s & wen & `LPWC_DPD_CAPABLE))
                    | rpin_s;

    // selected by present mode
    assign wake_any = (state_reg[1] & sleep_wake)
                    | (state_reg[2] & ds_wake)
                    | (state_reg[3] & dpd_wake)
                    | (state_reg[4] & dpd_wake & supply_s);

    // ---------------- mode state machine ----------------
    // requests only take effect from active; wake returns there
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_ACTIVE: begin
                case (req_reg)
                    `LPWC_REQ_SLEEP:  state_next = ST_SLEEP;
                    `LPWC_REQ_DSLEEP: state_next = ST_DSLEEP;
                    `LPWC_REQ_DPD:    state_next = ST_DPD;
                    `LPWC_REQ_FDPD:   state_next = ST_FDPD;
                    default:          state_next = ST_ACTIVE;
                endcase
            end
            ST_SLEEP, ST_DSLEEP, ST_DPD, ST_FDPD: begin
                if (wake_any) begin
                    state_next = ST_ACTIVE;
                end
            end
            default: state_next = ST_ACTIVE;   // illegal code recovers
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_ACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ---------------- wishbone slave ----------------
    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign bus_wr  = bus_req & we_i;

    // read mux, unmapped offsets read zero
    always @* begin
        case (adr_i)
            `LPWC_OFS_MODE:   rd_data = {29'h0, req_reg};
            `LPWC_OFS_WEN_LO: rd_data = {16'h0, wen_lo_reg};
            `LPWC_OFS_WEN_HI: rd_data = {24'h0, wen_hi_reg};
            `LPWC_OFS_IRQ_EN: rd_data = {8'h0, irq_en_reg};
            `LPWC_OFS_HW_SEL: rd_data = {23'h0, hw_sel_reg};
            `LPWC_OFS_CFG:    rd_data = {30'h0, cfg_reg};
            `LPWC_OFS_STATUS: rd_data = {27'h0, state_reg};
            `LPWC_OFS_CAUSE:  rd_data = {8'h0, cause_reg};
            default:          rd_data = 32'h0000_0000;
        endcase
    end

    // answer one cycle after the request, every address acked
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_req ? rd_data : 32'h0000_0000;
        end
    end

    // configuration registers, byte lanes honoured
    always @(posedge clk_i) begin
        if (rst_i) begin
            wen_lo_reg <= 16'h0000;
            wen_hi_reg <= 8'h00;
            irq_en_reg <= 24'h000000;
            hw_sel_reg <= `LPWC_HW_SEL_RESET;
            cfg_reg    <= `LPWC_CFG_RESET;
        end else if (bus_wr) begin
            case (adr_i)
                `LPWC_OFS_WEN_LO: begin
                    if (sel_i[0]) wen_lo_reg[7:0]  <= dat_i[7:0];
                    if (sel_i[1]) wen_lo_reg[15:8] <= dat_i[15:8];
                end
                `LPWC_OFS_WEN_HI: begin
                    if (sel_i[0]) wen_hi_reg <= dat_i[7:0];
                end
                `LPWC_OFS_IRQ_EN: begin
                    if (sel_i[0]) irq_en_reg[7:0]   <= dat_i[7:0];
                    if (sel_i[1]) irq_en_reg[15:8]  <= dat_i[15:8];
                    if (sel_i[2]) irq_en_reg[23:16] <= dat_i[23:16];
                end
                `LPWC_OFS_HW_SEL: begin
                    if (sel_i[0]) hw_sel_reg[7:0] <= dat_i[7:0];
                    if (sel_i[1]) hw_sel_reg[8]   <= dat_i[8];
                end
                `LPWC_OFS_CFG: begin
                    if (sel_i[0]) cfg_reg <= dat_i[1:0];
                end
                default: ;   // mode and cause are written below, other offsets hold no writable state
            endcase
        end
    end

    // mode request: written by software, consumed on entry so a
    // wake does not drop straight back into the same mode
    always @(posedge clk_i) begin
        if (rst_i) begin
            req_reg <= 3'h0;
        end else if (bus_wr && adr_i == `LPWC_OFS_MODE && sel_i[0]) begin
            req_reg <= dat_i[2:0];
        end else if (state_reg[0] && state_next != ST_ACTIVE) begin
            req_reg <= 3'h0;
        end
    end

    // cause record: write one to clear, a new cause wins the clash
    always @(posedge clk_i) begin
        if (rst_i) begin
            cause_reg <= 24'h000000;
        end else begin
            cause_reg <= (cause_reg
                          & ~((bus_wr && adr_i == `LPWC_OFS_CAUSE)
                              ? dat_i[23:0] : 24'h000000))
                       | ((wake_any && !state_reg[0]) ? irq_s
                                                      : 24'h000000);
        end
    end

    // ---------------- registered outputs ----------------
    // clock and power enables follow the mode being entered so
    // they switch in the same edge as the state itself
    always @(posedge clk_i) begin
        if (rst_i) begin
            cpu_clk_en_o    <= 1'b1;
            main_clk_en_o   <= 1'b1;
            periph_clk_en_o <= 1'b1;
            fro_en_o        <= 1'b1;
            osc_pwr_en_o    <= 1'b1;
            pll_pwr_en_o    <= 1'b1;
            sram_pwr_en_o   <= 1'b1;
            periph_pwr_en_o <= 1'b1;
            rtc_pwr_en_o    <= 1'b1;
            cmp_pwr_en_o    <= 1'b1;
            wake_req_o      <= 1'b0;
            chip_reset_o    <= 1'b0;
        end else begin
            cpu_clk_en_o    <= state_next[0];
            main_clk_en_o   <= state_next[0] | state_next[1];
            periph_clk_en_o <= state_next[0] | state_next[1];
            fro_en_o        <= state_next[0] | state_next[1];
            // retained across sleep and deep-sleep, off below that
            osc_pwr_en_o    <= ~(state_next[3] | state_next[4]);
            pll_pwr_en_o    <= ~(state_next[3] | state_next[4]);
            sram_pwr_en_o   <= ~(state_next[3] | state_next[4]);
            periph_pwr_en_o <= ~(state_next[3] | state_next[4]);
            rtc_pwr_en_o    <= cfg_reg[`LPWC_CFG_RTC_KEEP]
                             | state_next[0];
            // may stay on in deep-sleep, yet is masked from wake
            cmp_pwr_en_o    <= state_next[0] | state_next[1]
                             | (state_next[2]
                                & cfg_reg[`LPWC_CFG_CMP_KEEP]);
            wake_req_o      <= wake_any;
            chip_reset_o    <= primary_watchdog_s;
        end
    end

endmodule // lpwc_core

`default_nettype wire

// File: testbench/lpwc_core_monitor.sv
// lpwc_core_monitor.sv: port-level assertions for the wake control core.
// assumes: bound to lpwc_core, one clock, synchronous active-high reset.
`include "lpwc_map.vh"
`default_nettype none
module lpwc_core_monitor (
    // clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // wake side
    input wire logic [23:0] irq_i,
    input wire logic [8:0]  hw_act_i,
    input wire logic        reset_pin_n_i,
    input wire logic        supply_ok_i,
    input wire logic        primary_watchdog_rst_i,
    // power controls
    input wire logic        cpu_clk_en_o,
    input wire logic        main_clk_en_o,
    input wire logic        periph_clk_en_o,
    input wire logic        fro_en_o,
    input wire logic        osc_pwr_en_o,
    input wire logic        pll_pwr_en_o,
    input wire logic        sram_pwr_en_o,
    input wire logic        periph_pwr_en_o,
    input wire logic        cmp_pwr_en_o,
    input wire logic        wake_req_o,
    input wire logic        chip_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // request taken on this edge
    wire logic taken = cyc_i && stb_i && !ack_o;
    // a request taken while quiet and awake, asking for sleep
    wire logic go_sleep = taken && we_i && adr_i == `LPWC_OFS_MODE
        && sel_i[0] && dat_i[2:0] == `LPWC_REQ_SLEEP && cpu_clk_en_o
        && irq_i == 24'h0 && hw_act_i == 9'h0;
    // comparator alone raised while deep-sleep holds
    wire logic cmp_only = !main_clk_en_o && osc_pwr_en_o
        && irq_i == 24'h400000 && hw_act_i == 9'h0 && reset_pin_n_i;

    a_ack_on_time: assert property (taken |=> ack_o)
        else $error("ack missing after a taken request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_data_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_sleep_entry: assert property (go_sleep
        |=> ##1 !cpu_clk_en_o && main_clk_en_o)
        else $error("sleep did not stop the core clock alone");
    a_deep_clocks: assert property (!main_clk_en_o
        |-> !cpu_clk_en_o && !periph_clk_en_o && !fro_en_o)
        else $error("clock left running with main clock off");
    a_pd_power: assert property (!osc_pwr_en_o |-> !pll_pwr_en_o
        && !sram_pwr_en_o && !periph_pwr_en_o && !cmp_pwr_en_o
        && !main_clk_en_o)
        else $error("power domain left on in power-down");
    a_wdt_reset: assert property ($rose(primary_watchdog_rst_i)
        |-> ##3 chip_reset_o)
        else $error("primary watchdog reset not passed on");
    a_pin_wake: assert property ($fell(reset_pin_n_i)
        && !main_clk_en_o && supply_ok_i |-> ##[2:4] main_clk_en_o)
        else $error("reset pin did not wake the chip");
    a_wake_pulse: assert property ($rose(cpu_clk_en_o) |-> wake_req_o)
        else $error("wake request missing at wake-up");
    a_cmp_silent: assert property (cmp_only [*4] |=> !main_clk_en_o)
        else $error("comparator woke the chip");
    a_reset_state: assert property (disable iff (1'b0)
        rst_i |=> cpu_clk_en_o && osc_pwr_en_o && !wake_req_o
        && !chip_reset_o && !ack_o)
        else $error("outputs wrong during reset");

    // main scenarios reached
    c_sleep: cover property (go_sleep);
    c_pin: cover property ($fell(reset_pin_n_i) && !main_clk_en_o);
    c_wdt: cover property ($rose(chip_reset_o));
endmodule // lpwc_core_monitor

bind lpwc_core lpwc_core_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .irq_i, .hw_act_i,
    .reset_pin_n_i, .supply_ok_i, .primary_watchdog_rst_i, .cpu_clk_en_o,
    .main_clk_en_o, .periph_clk_en_o, .fro_en_o, .osc_pwr_en_o,
    .pll_pwr_en_o, .sram_pwr_en_o, .periph_pwr_en_o, .cmp_pwr_en_o,
    .wake_req_o, .chip_reset_o);
`default_nettype wire

// File: testbench/lpwc_periph_model.sv
// lpwc_periph_model.sv: peripheral side, raising interrupt and activity
// levels on command. assumes: commands change just after clock edges.
`default_nettype none
module lpwc_periph_model (
    // clock and commands
    input  wire logic        clk_i,
    input  wire logic        fire_i,
    input  wire logic [4:0]  src_i,
    input  wire logic [8:0]  lane_i,
    // levels toward the block
    output var  logic [23:0] irq_o,
    output var  logic [8:0]  hw_act_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels held until withdrawn, long enough for the synchroniser
    always_ff @(posedge clk_i) begin
        irq_o <= fire_i ? (24'h1 << src_i) : 24'h0;
        hw_act_o <= lane_i;
    end
endmodule // lpwc_periph_model
`default_nettype wire

// File: testbench/low_power_wake_control_test.sv
// low_power_wake_control_test.sv: self-checking bench for lpwc_core.
// assumes: design, monitor and model compiled first, map header found.
`include "lpwc_map.vh"
`default_nettype none
module low_power_wake_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    // one case: mode, source, slave, 32k, wake enable, irq enable, wake
    typedef struct packed {
        logic [2:0] md;
        logic [4:0] src;
        logic       sl, k32, wen, ien, ex;
    } lpwc_row_t;
    localparam logic [2:0] md_s = `LPWC_REQ_SLEEP;
    localparam logic [2:0] md_d = `LPWC_REQ_DSLEEP;
    localparam logic [2:0] md_p = `LPWC_REQ_DPD;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0]  adr_i = 0;
    logic [3:0]  sel_i = 0;
    logic [31:0] dat_i = 0, dat_o, rdat;
    logic ack_o, serial_slave_i = 1, usart_32k_i = 0, reset_pin_n_i = 1;
    logic supply_ok_i = 1, primary_watchdog_rst_i = 0, wdt_other_rst_i = 0, fire = 0;
    logic [4:0]  fire_src = 0;
    logic [8:0]  lane = 0, hw_act_i;
    logic [23:0] irq_i;
    logic cpu_clk_en_o, main_clk_en_o, periph_clk_en_o, fro_en_o;
    logic osc_pwr_en_o, pll_pwr_en_o, sram_pwr_en_o, periph_pwr_en_o;
    logic rtc_pwr_en_o, cmp_pwr_en_o, wake_req_o, chip_reset_o;
    int err_total = 0, tests_run = 0, cycles = 0;
    lpwc_row_t rows [12] = '{
        '{md_d, 14, 1, 0, 1, 1, 0},
        '{md_d, 22, 1, 0, 1, 1, 0},
        '{md_d, 15, 0, 1, 1, 1, 1},
        '{md_d, 15, 0, 0, 1, 1, 0},
        '{md_d, 16, 0, 0, 1, 1, 0},
        '{md_d, 19, 0, 0, 1, 1, 0},
        '{md_d, 6, 1, 0, 0, 1, 0},
        '{md_d, 6, 1, 0, 1, 0, 0},
        '{md_s, 22, 1, 0, 0, 1, 1},
        '{md_s, 14, 1, 0, 1, 0, 0},
        '{md_p, 2, 1, 0, 1, 0, 1},
        '{md_p, 6, 1, 0, 1, 1, 0}};

    lpwc_periph_model u_model (.clk_i, .fire_i(fire), .src_i(fire_src),
        .lane_i(lane), .irq_o(irq_i), .hw_act_o(hw_act_i));
    lpwc_core dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .irq_i, .hw_act_i, .serial_slave_i,
        .usart_32k_i, .reset_pin_n_i, .supply_ok_i, .primary_watchdog_rst_i,
        .wdt_other_rst_i, .cpu_clk_en_o, .main_clk_en_o, .periph_clk_en_o,
        .fro_en_o, .osc_pwr_en_o, .pll_pwr_en_o, .sram_pwr_en_o,
        .periph_pwr_en_o, .rtc_pwr_en_o, .cmp_pwr_en_o, .wake_req_o,
        .chip_reset_o);

    // 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // hang guard, well above the expected run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        // no local limit: only the hang guard ends a missing answer
        do @(posedge clk_i);
        while (ack_o !== 1'b1);
        rdat = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
    endtask
    // reset pin pulse: wakes from any mode without setup, full power-down only while supply_ok_i is high
    task automatic pin_wake();
        reset_pin_n_i <= 0;
        tk(6);
        reset_pin_n_i <= 1;
        tk(3);
    endtask
    task automatic enter(input logic [2:0] m);
        wb(1, `LPWC_OFS_MODE, {29'h0, m});
        tk(3);
    endtask
    task automatic run_row(input lpwc_row_t r);
        wb(1, `LPWC_OFS_WEN_LO, r.wen ? 32'hffff : 32'h0);
        wb(1, `LPWC_OFS_WEN_HI, r.wen ? 32'hff : 32'h0);
        wb(1, `LPWC_OFS_IRQ_EN, r.ien ? 32'hffffff : 32'h0);
        serial_slave_i <= r.sl;
        usart_32k_i <= r.k32;
        enter(r.md);
        chk("main_clk", r.md == md_s, main_clk_en_o);
        chk("sram", r.md != md_p, sram_pwr_en_o);
        chk("cmp", r.md != md_p, cmp_pwr_en_o);
        wb(0, `LPWC_OFS_STATUS, 0);
        chk("status", 32'h1 << r.md, rdat);
        fire_src <= r.src;
        fire <= 1;
        tk(8);
        chk("wake", r.ex, cpu_clk_en_o);
        fire <= 0;
        tk(4);
        if (cpu_clk_en_o !== 1'b1) pin_wake();
        chk("awake", 1, cpu_clk_en_o);
    endtask

    initial begin
        tk(3);
        rst_i <= 0;
        wb(0, `LPWC_OFS_CFG, 0);
        chk("cfg", `LPWC_CFG_RESET, rdat);
        wb(0, `LPWC_OFS_HW_SEL, 0);
        chk("hw_sel", `LPWC_HW_SEL_RESET, rdat);
        wb(0, 8'h20, 0);
        chk("unmapped", 0, rdat);
        // keep the comparator powered through deep-sleep from here on
        wb(1, `LPWC_OFS_CFG, 32'h3);
        for (int s = 0; s < 22; s++) begin
            if (s != `LPWC_SRC_WDT_OTHER)
                run_row('{md_d, s[4:0], 1, 0, 1, 1, 1});
        end
        foreach (rows[i]) run_row(rows[i]);
        // activity lanes: all in sleep, selected only in deep-sleep
        wb(1, `LPWC_OFS_HW_SEL, 32'h1);
        enter(md_s);
        lane <= 9'h100;
        tk(8);
        chk("hw_sleep", 1, cpu_clk_en_o);
        lane <= 9'h0;
        tk(4);
        enter(md_d);
        lane <= 9'h100;
        tk(8);
        chk("hw_unsel", 0, cpu_clk_en_o);
        lane <= 9'h1;
        tk(8);
        chk("hw_sel", 1, cpu_clk_en_o);
        lane <= 9'h0;
        tk(4);
        // full power-down waits for supply before the rtc wake source wakes
        wb(1, `LPWC_OFS_CAUSE, 32'hffffff);
        supply_ok_i <= 0;
        enter(`LPWC_REQ_FDPD);
        chk("rtc_keep", 1, rtc_pwr_en_o);
        fire_src <= `LPWC_SRC_RTC_WAKE;
        fire <= 1;
        tk(8);
        chk("fdpd_hold", 0, cpu_clk_en_o);
        supply_ok_i <= 1;
        tk(8);
        chk("fdpd_wake", 1, cpu_clk_en_o);
        fire <= 0;
        wb(0, `LPWC_OFS_CAUSE, 0);
        chk("cause", 32'h1 << `LPWC_SRC_RTC_WAKE, rdat);
        // only the primary watchdog resets the chip
        wdt_other_rst_i <= 1;
        tk(8);
        chk("wdt_other", 0, chip_reset_o);
        primary_watchdog_rst_i <= 1;
        tk(4);
        chk("primary_watchdog", 1, chip_reset_o);
        rst_i <= 1;
        primary_watchdog_rst_i <= 0;
        tk(3);
        rst_i <= 0;
        tk(2);
        chk("rst_clear", 0, chip_reset_o);
        end_of_test();
    end
endmodule // low_power_wake_control_test
`default_nettype wire
